// ===== omc_addr_decode.sv
`timescale 1ns/1ps
`include "omc_defs.svh"

// Combinational map of one memory address onto RAM, EPROM or external bus
module omc_addr_decode
    import omc_pkg::*;
#(
    parameter logic BANK_OFF_LEVEL = 1'b1
) (
    input  wire logic [15:0] addr_in,      // CPU memory address
    input  wire logic [3:0]  bank_ctl_in,  // Bank control bits
    input  wire logic        prom_off_in,  // EPROM disabled
    input  wire logic        jump_in,      // Power-on jump still armed
    output logic             ram_out,      // On-board RAM selected
    output logic             prom_out,     // EPROM selected
    output logic             ext_out       // Left to external memory
);

    logic bank_on;
    logic prom_hit;

    always_comb begin
        bank_on  = (bank_ctl_in[addr_in[15:14]] != BANK_OFF_LEVEL);
        prom_hit = !prom_off_in && (addr_in[15:12] == `OMC_PROM_PAGE);
        prom_out = prom_hit;
        // EPROM overlays RAM; once it is off the top page goes to RAM only with bank 3 on and the jump cleared
        ram_out  = !prom_hit && bank_on && !jump_in;
        ext_out  = !prom_hit && !ram_out;
    end

endmodule // omc_addr_decode

// ===== omc_cpu_model.sv
`timescale 1ns/1ps
// CPU side: issues one port access per call, caller sits just after an edge
module omc_cpu_model (
    input  wire logic       clk_in,    // CPU clock
    output logic [7:0]      addr_out,  // Port address
    output logic [7:0]      wdata_out, // Write byte
    output logic            wr_out,    // Write strobe
    output logic            rd_out     // Read strobe
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Held until the taking edge, so back-to-back calls need no gap
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        addr_out = a;
        wdata_out = d;
        wr_out = wr;
        rd_out = !wr;
        @(posedge clk_in);
        #1;
    endtask
    // Idle bus shows inverted values, never the stale byte
    task automatic bus_idle();
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask
endmodule // omc_cpu_model

// ===== omc_defs.svh
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH

// I/O port of the memory-map control register (hexadecimal)
`define OMC_PORT_ADDR      8'h16
// Field positions of the written byte
`define OMC_BANK_LSB       0
`define OMC_BANK_MSB       3
`define OMC_PROM_OFF_BIT   5
`define OMC_JUMP_CLR_BIT   6
// Reset values
`define OMC_BANK_RST       4'h0
`define OMC_PROM_OFF_RST   1'b0
// EPROM window: address bits 15:12 all ones
`define OMC_PROM_PAGE      4'hF

`endif

// ===== omc_mem_ctl.sv
`timescale 1ns/1ps
`include "omc_defs.svh"

// Contract
// - Port 16 is a write-only register of bank, EPROM and jump-clear bits.
// - Bits 0..3 each switch one 16K RAM bank, low bit lowest bank.
// - A switched-off bank leaves its range to external bus memory.
// - Bit 5 written 0 enables the EPROM, 1 disables it.
// - An enabled EPROM answers at F000h-FFFFh.
// - Reset forces the EPROM enabled without any write.
// - With the EPROM disabled, RAM answers in F000h-FFFFh; the code needs bank 3 on and the jump cleared, else external memory.
// - Writing bit 6 high clears the power-on jump circuit.
// - After reset RAM stays inaccessible until bit 6 is written high.
// - All port numbers and addresses are hexadecimal.
module omc_mem_ctl
    import omc_pkg::*;
#(
    parameter logic       BANK_OFF_LEVEL = 1'b1,
    parameter logic [3:0] BANK_RESET     = `OMC_BANK_RST
) (
    input  wire logic        clk_sys_in,   // System clock, 100 MHz
    input  wire logic        nrst_in,      // Synchronous reset, active low
    input  wire logic [7:0]  io_addr_in,   // I/O port address
    input  wire logic [7:0]  io_wdata_in,  // I/O write data
    input  wire logic        io_wr_in,     // I/O write strobe
    input  wire logic        io_rd_in,     // I/O read strobe
    input  wire logic [15:0] mem_addr_in,  // Memory address
    output logic [3:0]       bank_ctl_out, // Bank control bits as written
    output logic             prom_en_out,  // EPROM enabled
    output logic             jump_out,     // Power-on jump armed
    output logic             ram_sel_out,  // On-board RAM responds
    output logic             prom_sel_out, // EPROM responds
    output logic             ext_sel_out   // External bus memory serves
);

    omc_regs_t r_q;
    omc_regs_t r_d;
    logic      port_wr;
    logic      dec_ram;
    logic      dec_prom;
    logic      dec_ext;

    // Decode uses next-state controls so selects stay registered but current
    omc_addr_decode #(
        .BANK_OFF_LEVEL (BANK_OFF_LEVEL)
    ) u_dec (
        .addr_in     (mem_addr_in),
        .bank_ctl_in (r_d.bank_ctl),
        .prom_off_in (r_d.prom_off),
        .jump_in     (r_d.state == OMC_ST_JUMP),
        .ram_out     (dec_ram),
        .prom_out    (dec_prom),
        .ext_out     (dec_ext)
    );

    assign port_wr = io_wr_in && (io_addr_in == `OMC_PORT_ADDR);

    always_comb begin
        r_d = r_q;
        if (port_wr) begin
            r_d.bank_ctl = io_wdata_in[`OMC_BANK_MSB:`OMC_BANK_LSB];
            r_d.prom_off = io_wdata_in[`OMC_PROM_OFF_BIT];
        end
        case (r_q.state)
            OMC_ST_JUMP: begin
                if (port_wr && io_wdata_in[`OMC_JUMP_CLR_BIT]) begin
                    r_d.state = OMC_ST_RUN;
                end
            end
            OMC_ST_RUN: begin
                r_d.state = OMC_ST_RUN;
            end
            default: begin
                r_d.state = OMC_ST_JUMP;
            end
        endcase
        r_d.ram_sel  = dec_ram;
        r_d.prom_sel = dec_prom;
        r_d.ext_sel  = dec_ext;
        if (!nrst_in) begin
            r_d.state    = OMC_ST_JUMP;
            r_d.bank_ctl = BANK_RESET;
            r_d.prom_off = `OMC_PROM_OFF_RST;
            r_d.ram_sel  = 1'b0;
            r_d.prom_sel = 1'b0;
            r_d.ext_sel  = 1'b0;
        end
        // Output copies live in the state so every output pin leaves a flop
        r_d.prom_en = !r_d.prom_off;
        r_d.jump    = (r_d.state == OMC_ST_JUMP);
    end

    always_ff @(posedge clk_sys_in) begin
        r_q <= r_d;
    end

    assign bank_ctl_out = r_q.bank_ctl;
    assign prom_en_out  = r_q.prom_en;
    assign jump_out     = r_q.jump;
    assign ram_sel_out  = r_q.ram_sel;
    assign prom_sel_out = r_q.prom_sel;
    assign ext_sel_out  = r_q.ext_sel;

    // Selects lag the address by one cycle, so the checks look at it through $past
    function automatic logic bank_on_f(input logic [3:0] ctl, input logic [15:0] addr);
        return ctl[addr[15:14]] != BANK_OFF_LEVEL;
    endfunction

    function automatic logic prom_page_f(input logic [15:0] addr);
        return addr[15:12] == `OMC_PROM_PAGE;
    endfunction

    function automatic logic prom_hit_f(input logic en, input logic [15:0] addr);
        return en && prom_page_f(addr);
    endfunction

    AST_PORT_WRITE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        port_wr |=> bank_ctl_out == $past(io_wdata_in[3:0]))
        else $error("bank bits not loaded from port write");

    AST_PROM_BIT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        port_wr |=> prom_en_out == !$past(io_wdata_in[5]))
        else $error("EPROM enable does not follow bit 5");

    AST_RESET_PROM: assert property (@(posedge clk_sys_in)
        !nrst_in |=> prom_en_out && jump_out)
        else $error("reset did not enable EPROM and arm jump");

    AST_PROM_WIN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        prom_sel_out |-> prom_hit_f(prom_en_out, $past(mem_addr_in)))
        else $error("EPROM selected outside its window");

    AST_JUMP_BLOCK: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        jump_out |-> !ram_sel_out)
        else $error("RAM selected while jump armed");

    AST_JUMP_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        port_wr && io_wdata_in[6] |=> !jump_out)
        else $error("bit 6 write did not clear jump");

    AST_BANK_OFF: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ram_sel_out |-> bank_on_f(bank_ctl_out, $past(mem_addr_in)))
        else $error("RAM selected in a switched-off bank");

    AST_TOP_RAM: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $past(nrst_in) && !jump_out && !prom_en_out && prom_page_f($past(mem_addr_in))
        && bank_on_f(bank_ctl_out, $past(mem_addr_in)) |-> ram_sel_out)
        else $error("RAM not reachable in top page with EPROM off");

    AST_READ_QUIET: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        io_rd_in && !io_wr_in
        |=> $stable(bank_ctl_out) && $stable(prom_en_out) && $stable(jump_out))
        else $error("port read altered control state");

    AST_ONE_SEL: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $past(nrst_in) |-> $onehot({ram_sel_out, prom_sel_out, ext_sel_out}))
        else $error("memory selects not one-hot");

    AST_RESET_BANKS: assert property (@(posedge clk_sys_in)
        !nrst_in |=> bank_ctl_out == BANK_RESET)
        else $error("bank bits not at their reset value");

    AST_RESET_SELS: assert property (@(posedge clk_sys_in)
        !nrst_in |=> !ram_sel_out && !prom_sel_out && !ext_sel_out)
        else $error("memory selects not cleared by reset");

    AST_JUMP_STICKY: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !jump_out |=> !jump_out)
        else $error("jump armed again without reset");

    AST_JUMP_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        jump_out && !(port_wr && io_wdata_in[`OMC_JUMP_CLR_BIT]) |=> jump_out)
        else $error("jump cleared without a bit 6 write");

    AST_JUMP_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $fell(jump_out) |-> $past(port_wr) && $past(io_wdata_in[`OMC_JUMP_CLR_BIT]))
        else $error("jump fell with no bit 6 write");

    AST_OTHER_PORT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        io_wr_in && io_addr_in != `OMC_PORT_ADDR
        |=> $stable(bank_ctl_out) && $stable(prom_en_out) && $stable(jump_out))
        else $error("write to another port altered control state");

    AST_BANK_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $changed(bank_ctl_out) |-> $past(port_wr) || !$past(nrst_in))
        else $error("bank bits changed with no port write");

    AST_PROM_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $changed(prom_en_out) |-> $past(port_wr) || !$past(nrst_in))
        else $error("EPROM enable changed with no port write");

    AST_PROM_OFF_QUIET: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !prom_en_out |-> !prom_sel_out)
        else $error("EPROM selected while disabled");

    AST_PROM_HIT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $past(nrst_in) && prom_hit_f(prom_en_out, $past(mem_addr_in)) |-> prom_sel_out)
        else $error("enabled EPROM did not answer in its window");

    AST_EXT_JUMP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $past(nrst_in) && jump_out && !prom_hit_f(prom_en_out, $past(mem_addr_in))
        |-> ext_sel_out)
        else $error("access not passed to external memory while jump armed");

    AST_BANK_ON_RAM: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $past(nrst_in) && !jump_out && bank_on_f(bank_ctl_out, $past(mem_addr_in))
        && !prom_hit_f(prom_en_out, $past(mem_addr_in)) |-> ram_sel_out)
        else $error("RAM silent in a switched-on bank");

    AST_BANK_OFF_EXT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $past(nrst_in) && !bank_on_f(bank_ctl_out, $past(mem_addr_in))
        && !prom_hit_f(prom_en_out, $past(mem_addr_in)) |-> ext_sel_out)
        else $error("switched-off bank not left to external memory");

    AST_STATE_LEGAL: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        r_q.state inside {OMC_ST_JUMP, OMC_ST_RUN})
        else $error("control state outside its legal set");

    COV_JUMP_CLR: cover property (@(posedge clk_sys_in) jump_out ##1 !jump_out);
    COV_PROM_OFF: cover property (@(posedge clk_sys_in) !prom_en_out && ram_sel_out);
    COV_EXT: cover property (@(posedge clk_sys_in) !jump_out && ext_sel_out);
    COV_PROM_HIT: cover property (@(posedge clk_sys_in) prom_sel_out && !jump_out);
    COV_OTHER_PORT: cover property (@(posedge clk_sys_in)
        io_wr_in && io_addr_in != `OMC_PORT_ADDR);

endmodule // omc_mem_ctl

// ===== omc_mem_ctl_tb_top.sv
`timescale 1ns/1ps
module omc_mem_ctl_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        nrst_in    = 1'b0;
    logic [15:0] mem_addr   = 16'h0000;
    logic [7:0]  io_addr, io_wdata;
    logic        io_wr, io_rd, prom_en, jump, ram_sel, prom_sel, ext_sel;
    logic [3:0]  bank;
    int          miscompares = 0;
    int          cmp_count   = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    omc_cpu_model cpu (.clk_in(clk_sys_in), .addr_out(io_addr), .wdata_out(io_wdata),
        .wr_out(io_wr), .rd_out(io_rd));
    omc_mem_ctl uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .io_addr_in(io_addr),
        .io_wdata_in(io_wdata), .io_wr_in(io_wr), .io_rd_in(io_rd), .mem_addr_in(mem_addr),
        .bank_ctl_out(bank), .prom_en_out(prom_en), .jump_out(jump), .ram_sel_out(ram_sel),
        .prom_sel_out(prom_sel), .ext_sel_out(ext_sel));
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Expected select as {ram, prom, ext}, seen one cycle after the address
    task automatic probe(input logic [15:0] a, input logic [2:0] e);
        mem_addr = a;
        @(posedge clk_sys_in);
        #1;
        chk("select", {5'h00, e}, {5'h00, ram_sel, prom_sel, ext_sel});
    endtask
    task automatic ctl(input logic [7:0] e);
        chk("control", e, {2'b00, jump, prom_en, bank});
    endtask
    task automatic t_reset();
        ctl(8'h30);
        probe(16'h0000, 3'b001);
        probe(16'hF000, 3'b010);
    endtask
    task automatic t_ignore();
        cpu.access(8'h15, 8'h40, 1'b1);
        cpu.access(8'h16, 8'h40, 1'b0);
        cpu.bus_idle();
        ctl(8'h30);
    endtask
    task automatic t_clear();
        cpu.access(8'h16, 8'h40, 1'b1);
        cpu.bus_idle();
        ctl(8'h10);
        probe(16'h0000, 3'b100);
        probe(16'hF800, 3'b010);
    endtask
    task automatic t_banks();
        for (int i = 0; i < 4; i++) begin
            cpu.access(8'h16, 8'hD0 | (8'h01 << i), 1'b1);
            cpu.bus_idle();
            ctl({4'h1, 4'h1 << i});
            probe({2'(i), 14'h0001}, 3'b001);
            probe({2'(i + 1), 14'h0000}, 3'b100);
        end
    endtask
    task automatic t_prom();
        cpu.access(8'h16, 8'h60, 1'b1);
        cpu.access(8'h16, 8'h20, 1'b1);
        cpu.bus_idle();
        ctl(8'h00);
        probe(16'hF000, 3'b100);
        cpu.access(8'h16, 8'h28, 1'b1);
        cpu.bus_idle();
        probe(16'hF000, 3'b001);
        nrst_in = 1'b0;
        @(posedge clk_sys_in);
        #1;
        ctl(8'h30);
        chk("select", 8'h00, {5'h00, ram_sel, prom_sel, ext_sel});
        nrst_in = 1'b1;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_in);
        #1;
        nrst_in = 1'b1;
        t_reset();
        t_ignore();
        t_clear();
        t_banks();
        t_prom();
        t_reset();
        final_report();
    end
    // Guard against a stalled run
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule // omc_mem_ctl_tb_top

// ===== omc_pkg.sv
package omc_pkg;

    typedef enum logic [1:0] {
        OMC_ST_JUMP,
        OMC_ST_RUN
    } omc_state_t;

    typedef struct packed {
        omc_state_t state;
        logic [3:0] bank_ctl;
        logic       prom_off;
        logic       ram_sel;
        logic       prom_sel;
        logic       ext_sel;
        logic       prom_en;
        logic       jump;
    } omc_regs_t;

endpackage
